//--- xdp_pkg.sv
// Constants and types shared by the exclusive-OR instruction datapath.
// Assumes a 14-bit instruction word and an 8-bit accumulator and data memory.
package xdp_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int XDP_INSTR_W = 14;         // Program word width
  localparam int XDP_DATA_W = 8;           // Accumulator and memory data width
  localparam int XDP_ADDR_W = 7;           // Data memory address field width
  localparam int XDP_OPC_W = 6;            // Upper opcode field width

  // ==========================================================================
  // Opcode fields
  // ==========================================================================
  localparam int XDP_OPC_HI = 13;          // Top bit of the opcode field
  localparam int XDP_OPC_LO = 8;           // Bottom bit of the opcode field
  localparam int XDP_LIT_HI = 7;           // Top bit of the literal
  localparam int XDP_LIT_LO = 0;           // Bottom bit of the literal
  localparam int XDP_DEST_BIT = 7;         // Destination select in register form
  localparam int XDP_ADDR_HI = 6;          // Top bit of register address
  localparam int XDP_ADDR_LO = 0;          // Bottom bit of register address
  localparam logic [5:0] XDP_OPC_XOR_LIT = 6'h3a;  // Immediate form, 11 1010
  localparam logic [5:0] XDP_OPC_XOR_REG = 6'h06;  // Register form, 00 0110

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0] XDP_ACCUM_RST = 8'h00;    // Accumulator after reset
  localparam logic [6:0] XDP_ADDR_RST = 7'h00;     // Memory address after reset

  // ==========================================================================
  // Types
  // ==========================================================================
  // Quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    XDP_Q1 = 2'b00,
    XDP_Q2 = 2'b01,
    XDP_Q3 = 2'b10,
    XDP_Q4 = 2'b11
  } xdp_phase_t;

  // Decoded instruction kind
  typedef enum logic [1:0] {
    XDP_K_NONE = 2'b00,
    XDP_K_LIT = 2'b01,
    XDP_K_REG = 2'b10
  } xdp_kind_t;

endpackage : xdp_pkg

//--- xdp_core.sv
// Exclusive-OR instruction datapath: decode, operand read, operation, write.
// Assumes a data memory that returns read data in the cycle its read strobe
// is high, and an instruction word presented during the first quarter phase.
//
// What this block does
// [RULE1] Decode immediate form, top six bits 111010
// [RULE2] Immediate form: accumulator XOR literal into accumulator
// [RULE3] Register form, select 0: result to accumulator
// [RULE4] Register form, select 1: result to register
// [RULE5] One word, one instruction cycle, no stalls
// [RULE6] Four quarter phases: decode, read, operate, write
// [RULE7] Zero flag follows the 8-bit result
// [RULE8] Register form: bit 7 select, bits 6:0 address
`timescale 1ns/1ps

module xdp_core
  import xdp_pkg::*;
(
  input wire logic i_core_clk,                       // Core clock, 250 MHz
  input wire logic i_rst_n,                          // Asynchronous reset, active low
  input wire logic i_instr_valid,                    // Instruction word present in Q1
  input wire logic [XDP_INSTR_W-1:0] i_instr,        // Fetched program word
  input wire logic [XDP_DATA_W-1:0] i_mem_rdata,     // Data memory read data
  output logic [1:0] o_phase,                        // Current quarter phase
  output logic [XDP_DATA_W-1:0] o_accum,             // Accumulator contents
  output logic o_zero,                               // Zero flag
  output logic o_mem_rd,                             // Data memory read strobe
  output logic [XDP_ADDR_W-1:0] o_mem_addr,          // Data memory address
  output logic o_mem_wr,                             // Data memory write strobe
  output logic [XDP_DATA_W-1:0] o_mem_wdata,         // Data memory write data
  output logic o_done                                // Instruction retired pulse
);

  // ==========================================================================
  // State
  // ==========================================================================
  // All state in one record so the update is one comb and one flop process
  typedef struct packed {
    xdp_phase_t phase;                     // Quarter phase counter
    xdp_kind_t kind;                       // Instruction in flight
    logic dest_reg;                        // Result goes to memory register
    logic [XDP_DATA_W-1:0] literal;        // Literal held from decode
    logic [XDP_DATA_W-1:0] operand;        // Second operand for the XOR
    logic [XDP_DATA_W-1:0] result;         // XOR result held for write-back
    logic [XDP_DATA_W-1:0] accum;          // Accumulator
    logic zero;                            // Zero flag
    logic mem_rd;                          // Read strobe
    logic [XDP_ADDR_W-1:0] mem_addr;       // Register address
    logic mem_wr;                          // Write strobe
    logic [XDP_DATA_W-1:0] mem_wdata;      // Write data
    logic done;                            // Retire pulse
  } xdp_state_t;

  xdp_state_t st_r;                        // Registered state
  xdp_state_t st_nxt;                      // Next state
  logic [XDP_OPC_W-1:0] opc;               // Opcode field of incoming word
  xdp_kind_t dec_kind;                     // Decode of incoming word

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Opcode field of the incoming word
  assign opc = i_instr[XDP_OPC_HI:XDP_OPC_LO];

  // Recognise the two forms; anything else passes through as a no-op
  always_comb begin
    if (!i_instr_valid) begin
      dec_kind = XDP_K_NONE;
    end else if (opc == XDP_OPC_XOR_LIT) begin
      dec_kind = XDP_K_LIT; // RULE1
    end else if (opc == XDP_OPC_XOR_REG) begin
      dec_kind = XDP_K_REG; // RULE8
    end else begin
      dec_kind = XDP_K_NONE;
    end
  end

  // ==========================================================================
  // Next state
  // ==========================================================================
  // Phase sequencer and datapath; one phase per clock, never stalls
  always_comb begin
    st_nxt = st_r;
    st_nxt.phase = xdp_phase_t'(st_r.phase + 2'b01); // RULE6
    st_nxt.done = 1'b0;
    case (st_r.phase)
      XDP_Q1: begin
        // Decode and latch the fields
        st_nxt.kind = dec_kind; // RULE6
        st_nxt.dest_reg = i_instr[XDP_DEST_BIT]; // RULE8
        st_nxt.literal = i_instr[XDP_LIT_HI:XDP_LIT_LO];
        st_nxt.mem_addr = i_instr[XDP_ADDR_HI:XDP_ADDR_LO]; // RULE8
        st_nxt.mem_rd = (dec_kind == XDP_K_REG);
      end
      XDP_Q2: begin
        // Operand read: literal or the addressed register
        if (st_r.kind == XDP_K_REG) begin
          st_nxt.operand = i_mem_rdata;
        end else begin
          st_nxt.operand = st_r.literal; // RULE2
        end
        st_nxt.mem_rd = 1'b0;
      end
      XDP_Q3: begin
        // Operation; memory write strobe prepared for Q4
        st_nxt.result = st_r.accum ^ st_r.operand; // RULE2
        if (st_r.kind == XDP_K_REG && st_r.dest_reg) begin
          st_nxt.mem_wr = 1'b1; // RULE4
          st_nxt.mem_wdata = st_r.accum ^ st_r.operand;
        end
      end
      default: begin
        // Q4 write-back; the instruction retires at this edge
        st_nxt.mem_wr = 1'b0;
        if (st_r.kind != XDP_K_NONE) begin
          st_nxt.zero = (st_r.result == '0); // RULE7
          st_nxt.done = 1'b1; // RULE5
          if (st_r.kind == XDP_K_LIT || !st_r.dest_reg) begin
            st_nxt.accum = st_r.result; // RULE3
          end
        end
        st_nxt.kind = XDP_K_NONE;
      end
    endcase
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  // State flops; reset loads constants only
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_r <= '{phase: XDP_Q1, kind: XDP_K_NONE, dest_reg: 1'b0, literal: '0,
                operand: '0, result: '0, accum: XDP_ACCUM_RST, zero: 1'b0,
                mem_rd: 1'b0, mem_addr: XDP_ADDR_RST, mem_wr: 1'b0,
                mem_wdata: '0, done: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Every output is a state flop, no logic after the register
  assign o_phase = st_r.phase;
  assign o_accum = st_r.accum;
  assign o_zero = st_r.zero;
  assign o_mem_rd = st_r.mem_rd;
  assign o_mem_addr = st_r.mem_addr;
  assign o_mem_wr = st_r.mem_wr;
  assign o_mem_wdata = st_r.mem_wdata;
  assign o_done = st_r.done;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_rst_n);

  // Valid immediate-form word seen at decode
  sequence s_lit_decode;
    st_r.phase == XDP_Q1 && i_instr_valid && opc == XDP_OPC_XOR_LIT;
  endsequence

  // Valid register-form word seen at decode
  sequence s_reg_decode;
    st_r.phase == XDP_Q1 && i_instr_valid && opc == XDP_OPC_XOR_REG;
  endsequence

  // Phases walk Q1 to Q4 in order
  sequence s_phase_walk;
    st_r.phase == XDP_Q2 ##1 st_r.phase == XDP_Q3 ##1 st_r.phase == XDP_Q4
      ##1 st_r.phase == XDP_Q1;
  endsequence

  property p_phase_order;
    st_r.phase == XDP_Q1 |-> ##1 s_phase_walk;
  endproperty
  a_phase_order: assert property (p_phase_order) else $error("phase order broken"); // RULE6

  property p_lit_result;
    s_lit_decode |-> ##4
      (o_accum == ($past(o_accum, 4) ^ $past(i_instr[XDP_LIT_HI:XDP_LIT_LO], 4)));
  endproperty
  a_lit_result: assert property (p_lit_result) else $error("literal xor wrong"); // RULE2

  property p_lit_no_mem;
    s_lit_decode |-> ##1 (!o_mem_rd && !o_mem_wr) [*4];
  endproperty
  a_lit_no_mem: assert property (p_lit_no_mem) else $error("literal form used memory"); // RULE1

  property p_one_cycle;
    (s_lit_decode or s_reg_decode) |-> ##1 !o_done [*3] ##1 o_done;
  endproperty
  a_one_cycle: assert property (p_one_cycle) else $error("retire not at cycle end"); // RULE5

  property p_zero_flag;
    // Rebuilt from the old accumulator and the operand, not from the result flop
    (s_lit_decode or s_reg_decode) |-> ##4
      (o_zero == (($past(o_accum, 4) ^ $past(st_r.operand, 2)) == '0));
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("zero flag wrong"); // RULE7

  property p_reg_read;
    s_reg_decode |-> ##1 (o_mem_rd && o_mem_addr == $past(i_instr[XDP_ADDR_HI:XDP_ADDR_LO]))
      ##1 !o_mem_rd;
  endproperty
  a_reg_read: assert property (p_reg_read) else $error("register read missing"); // RULE8

  property p_reg_to_accum;
    s_reg_decode ##0 !i_instr[XDP_DEST_BIT] |-> ##2 st_r.operand == $past(i_mem_rdata)
      ##2 (o_accum == ($past(o_accum, 4) ^ $past(st_r.operand, 2)) && !$past(o_mem_wr));
  endproperty
  a_reg_to_accum: assert property (p_reg_to_accum) else $error("select 0 wrong"); // RULE3

  property p_reg_to_mem;
    s_reg_decode ##0 i_instr[XDP_DEST_BIT] |-> ##3 (o_mem_wr &&
      o_mem_wdata == (o_accum ^ st_r.operand)) ##1 (!o_mem_wr && o_accum == $past(o_accum, 4));
  endproperty
  a_reg_to_mem: assert property (p_reg_to_mem) else $error("select 1 wrong"); // RULE4

  property p_wr_only_q4;
    o_mem_wr |-> st_r.phase == XDP_Q4;
  endproperty
  a_wr_only_q4: assert property (p_wr_only_q4) else $error("write outside Q4"); // RULE6

endmodule : xdp_core

//--- xor_instruction_datapath_bench.sv
// Self-checking bench for the exclusive-OR instruction datapath core.
// Assumes the core retires each word four cycles after its Q1 and reads
// memory data in the same cycle as its read strobe.
`timescale 1ns/1ps

module xor_instruction_datapath_bench;
  import xdp_pkg::*;

  // ==========================================================================
  // Signals and reference model state
  // ==========================================================================
  logic i_core_clk; // Core clock
  logic i_rst_n; // Reset, active low
  logic i_instr_valid; // Word present
  logic [XDP_INSTR_W-1:0] i_instr; // Program word
  logic [XDP_DATA_W-1:0] i_mem_rdata; // Memory read data
  logic [1:0] o_phase;
  logic [XDP_DATA_W-1:0] o_accum;
  logic o_zero;
  logic o_mem_rd;
  logic [XDP_ADDR_W-1:0] o_mem_addr;
  logic o_mem_wr;
  logic [XDP_DATA_W-1:0] o_mem_wdata;
  logic o_done;
  int failures; // Mismatch count
  int total_checks; // Comparison count
  logic [7:0] m_accum; // Model accumulator
  logic m_zero; // Model zero flag

  xdp_core i_xdp_core (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_instr_valid(i_instr_valid),
    .i_instr(i_instr),
    .i_mem_rdata(i_mem_rdata),
    .o_phase(o_phase),
    .o_accum(o_accum),
    .o_zero(o_zero),
    .o_mem_rd(o_mem_rd),
    .o_mem_addr(o_mem_addr),
    .o_mem_wr(o_mem_wr),
    .o_mem_wdata(o_mem_wdata),
    .o_done(o_done)
  );

  // ==========================================================================
  // Clock, 4 ns period
  // ==========================================================================
  always #2 i_core_clk = ~i_core_clk;

  // ==========================================================================
  // Compare and report helpers
  // ==========================================================================
  // Case inequality so an unknown never passes
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    if (failures == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  // ==========================================================================
  // One instruction slot, entered at the falling edge of a Q1 cycle
  // ==========================================================================
  // Words offered outside Q1 must be ignored, so a live word stays on them
  task automatic run_one(input logic v, input logic [13:0] word, input logic [7:0] rd);
    logic is_lit;
    logic is_reg;
    logic to_reg;
    logic [7:0] res;
    is_lit = v && (word[13:8] === XDP_OPC_XOR_LIT);
    is_reg = v && (word[13:8] === XDP_OPC_XOR_REG);
    to_reg = is_reg && word[XDP_DEST_BIT];
    check(o_phase, XDP_Q1);
    i_instr_valid = v;
    i_instr = word;
    @(negedge i_core_clk);
    i_instr_valid = 1'b1;
    i_instr = {XDP_OPC_XOR_LIT, 8'(($urandom % 255) + 1)};
    check(o_phase, XDP_Q2);
    check(o_done, 1'b0);
    check(o_mem_rd, is_reg);
    if (is_reg) check(o_mem_addr, word[6:0]);
    i_mem_rdata = rd;
    @(negedge i_core_clk);
    // Data no longer valid, so scramble it
    i_mem_rdata = ~rd;
    check(o_phase, XDP_Q3);
    check({o_mem_rd, o_mem_wr}, 2'b00);
    res = m_accum ^ (is_lit ? word[7:0] : rd);
    @(negedge i_core_clk);
    check(o_mem_wr, to_reg);
    if (to_reg) check(o_mem_wdata, res);
    if (is_lit || is_reg) begin
      if (!to_reg) m_accum = res;
      m_zero = (res == 8'h00);
    end
    @(negedge i_core_clk);
    check(o_done, is_lit || is_reg);
    check(o_accum, m_accum);
    check(o_zero, m_zero);
    check(o_mem_wr, 1'b0);
  endtask : run_one

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    int n;
    logic [5:0] opc;
    i_core_clk = 1'b0;
    i_rst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_instr = 14'h0000;
    i_mem_rdata = 8'h00;
    failures = 0;
    total_checks = 0;
    m_accum = XDP_ACCUM_RST;
    m_zero = 1'b0;
    void'($urandom(37));
    repeat (20) @(posedge i_core_clk);
    @(negedge i_core_clk);
    check(o_accum, XDP_ACCUM_RST);
    check(o_zero, 1'b0);
    check(o_done, 1'b0);
    check(o_phase, XDP_Q1);
    i_rst_n = 1'b1;
    for (n = 0; n < 8 && o_phase !== 2'b00; n++) @(negedge i_core_clk);
    if (n == 8) begin
      failures++;
      end_of_test();
    end
    // Worked pair, then both register destinations, the second giving a zero result
    run_one(1'b1, {XDP_OPC_XOR_LIT, 8'hb5}, 8'h00);
    run_one(1'b1, {XDP_OPC_XOR_LIT, 8'haf}, 8'h00);
    run_one(1'b1, {XDP_OPC_XOR_REG, 1'b1, 7'h7f}, 8'haf);
    run_one(1'b1, {XDP_OPC_XOR_REG, 1'b0, 7'h00}, 8'h1a);
    // Random mix: both forms, idle slots, unknown opcodes
    for (int k = 0; k < 300; k++) begin
      opc = 6'($urandom);
      if (k % 3 == 0) opc = XDP_OPC_XOR_LIT;
      if (k % 3 == 1) opc = XDP_OPC_XOR_REG;
      run_one(($urandom % 6) != 0, {opc, 8'($urandom)}, 8'($urandom));
    end
    // Reset in mid-run, then one more slot from a clean start
    i_rst_n = 1'b0;
    @(negedge i_core_clk);
    check(o_accum, XDP_ACCUM_RST);
    check(o_zero, 1'b0);
    check(o_done, 1'b0);
    check({o_mem_rd, o_mem_wr}, 2'b00);
    check(o_phase, XDP_Q1);
    m_accum = XDP_ACCUM_RST;
    m_zero = 1'b0;
    i_rst_n = 1'b1;
    run_one(1'b1, {XDP_OPC_XOR_LIT, 8'h3c}, 8'h00);
    end_of_test();
  end

  // Watchdog against a hung run
  initial begin
    #40000;
    failures++;
    end_of_test();
  end

endmodule : xor_instruction_datapath_bench
